/* File: rtl/irq_pkg.sv */
// Function
// - Edge select 00 off, 01 rising, 10 falling, 11 both edges.
// - Source events set their flag regardless of any enable.
// - A flag vectors only when its own enable is one.
// - Global enable zero blocks every interrupt.
// - Taking an interrupt pushes next PC and loads the vector.
// - Every source has its own distinct vector address.
// - Servicing an interrupt clears the global enable.
// - Requests during service still set and hold their flags.
// - No request is acknowledged while the stack is full.
// - Interrupt return pops the saved program counter.
// - Any flag rising wakes the device from sleep or idle.
// - Pin flag sets on the selected edge of the request pin.
// - Servicing the pin interrupt clears its flag and global enable.
// - Pull-high selection stays valid while the pin is an interrupt input.
// - Register 0: timer flag 6, pin flag 4, enables 3, 1, global 0.
// - Register 0 bits 5 and 2 stay zero and ignore writes.
// - Register 1: reload 6, empty 5, tick 4 flags; enables 2, 1, 0.
// - Flags and enables reset to zero, are read/write, unused bits read zero.
// - Interrupt return sets global enable; plain return leaves it.
// - Buffer-empty flag sets on empty, clears when serviced.
// - Reload-done flag sets on reload, clears when serviced.
// - Timer and tick flags set on overflow, clear when serviced.
package irq_pkg;

	localparam logic [11:0] addr_edge_sel = 12'h000;
	localparam logic [11:0] addr_ctrl0 = 12'h004;
	localparam logic [11:0] addr_ctrl1 = 12'h008;
	localparam logic [11:0] addr_status = 12'h00c;

	localparam int pos_pin_en = 1;
	localparam int pos_global_en = 0;
	localparam int pos_timer_en = 3;
	localparam int pos_pin_flag = 4;
	localparam int pos_timer_flag = 6;
	localparam int pos_tick_en = 0;
	localparam int pos_void_en = 1;
	localparam int pos_reload_en = 2;
	localparam int pos_tick_flag = 4;
	localparam int pos_void_flag = 5;
	localparam int pos_reload_flag = 6;

	localparam logic [7:0] reset_byte = 8'h00;
	localparam logic [1:0] edge_off = 2'h0;
	localparam logic [1:0] edge_rise = 2'h1;
	localparam logic [1:0] edge_fall = 2'h2;
	localparam logic [1:0] edge_both = 2'h3;

	localparam int num_src = 5;
	localparam int pc_w = 12;
	// Source order is also priority order, index 0 highest.
	localparam int src_pin = 0;
	localparam int src_timer = 1;
	localparam int src_tick = 2;
	localparam int src_void = 3;
	localparam int src_reload = 4;

	localparam logic [pc_w-1:0] vec_pin = 12'h004;
	localparam logic [pc_w-1:0] vec_timer = 12'h008;
	localparam logic [pc_w-1:0] vec_tick = 12'h00c;
	localparam logic [pc_w-1:0] vec_void = 12'h010;
	localparam logic [pc_w-1:0] vec_reload = 12'h014;

	typedef struct packed {
		logic [pc_w-1:0] next_pc;
		logic stack_full;
		logic ret_irq;
		logic ret_plain;
		logic take_ack;
	} core_in_t;

	typedef struct packed {
		logic take_req;
		logic [pc_w-1:0] vector;
		logic push;
		logic [pc_w-1:0] push_pc;
		logic wake;
	} core_out_t;

endpackage

/* File: rtl/irq_pick.sv */
`timescale 1ns/1ps
module irq_pick (
	input wire logic [irq_pkg::num_src-1:0] pending,
	output logic found,
	output logic [2:0] index
);
	// Lowest index wins, so the search runs from the top down.
	always_comb begin
		found = 1'b0;
		index = 3'h0;
		for (int i = irq_pkg::num_src - 1; i >= 0; i--) begin
			if (pending[i]) begin
				found = 1'b1;
				index = 3'(i);
			end
		end
	end
endmodule // irq_pick

/* File: rtl/irq_controller.sv */
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module irq_controller (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic irq_pin,
	input wire logic timer_ovf,
	input wire logic tick_ovf,
	input wire logic buf_void,
	input wire logic reload_done,
	input wire logic pin_pull_sel,
	output logic pin_pull_en,
	input wire irq_pkg::core_in_t core_in,
	output irq_pkg::core_out_t core_out
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_take = 2'b10
	} phase_t;

	typedef struct packed {
		phase_t phase;
		logic [1:0] pin_edge_sel;
		logic global_irq_en;
		logic [irq_pkg::num_src-1:0] en;
		logic [irq_pkg::num_src-1:0] flag;
		logic pin_prev;
		logic [2:0] sel;
		logic [irq_pkg::pc_w-1:0] saved_pc;
		logic wake;
		logic [31:0] rdata;
	} state_t;

	state_t s;
	state_t next_s;

	logic [irq_pkg::num_src-1:0] pending;
	logic found;
	logic [2:0] pick;
	logic rise;
	logic fall;
	logic pin_event;
	logic [irq_pkg::num_src-1:0] events;
	logic wr;
	logic rd;
	logic mapped;

	function automatic logic [irq_pkg::pc_w-1:0] vector_of(input logic [2:0] idx);
		unique case (idx)
			3'h0: vector_of = irq_pkg::vec_pin;
			3'h1: vector_of = irq_pkg::vec_timer;
			3'h2: vector_of = irq_pkg::vec_tick;
			3'h3: vector_of = irq_pkg::vec_void;
			default: vector_of = irq_pkg::vec_reload;
		endcase
	endfunction

	function automatic logic [7:0] ctrl0_of(input state_t v);
		ctrl0_of = irq_pkg::reset_byte;
		ctrl0_of[irq_pkg::pos_timer_flag] = v.flag[irq_pkg::src_timer];
		ctrl0_of[irq_pkg::pos_pin_flag] = v.flag[irq_pkg::src_pin];
		ctrl0_of[irq_pkg::pos_timer_en] = v.en[irq_pkg::src_timer];
		ctrl0_of[irq_pkg::pos_pin_en] = v.en[irq_pkg::src_pin];
		ctrl0_of[irq_pkg::pos_global_en] = v.global_irq_en;
	endfunction

	function automatic logic [7:0] ctrl1_of(input state_t v);
		ctrl1_of = irq_pkg::reset_byte;
		ctrl1_of[irq_pkg::pos_reload_flag] = v.flag[irq_pkg::src_reload];
		ctrl1_of[irq_pkg::pos_void_flag] = v.flag[irq_pkg::src_void];
		ctrl1_of[irq_pkg::pos_tick_flag] = v.flag[irq_pkg::src_tick];
		ctrl1_of[irq_pkg::pos_reload_en] = v.en[irq_pkg::src_reload];
		ctrl1_of[irq_pkg::pos_void_en] = v.en[irq_pkg::src_void];
		ctrl1_of[irq_pkg::pos_tick_en] = v.en[irq_pkg::src_tick];
	endfunction

	// ----------------------------------------------------------------
	// Edge detection and source events
	// ----------------------------------------------------------------
	assign rise = irq_pin & ~s.pin_prev;
	assign fall = ~irq_pin & s.pin_prev;
	always_comb begin
		unique case (s.pin_edge_sel)
			irq_pkg::edge_rise: pin_event = rise;
			irq_pkg::edge_fall: pin_event = fall;
			irq_pkg::edge_both: pin_event = rise | fall;
			default: pin_event = 1'b0;
		endcase
	end

	// The pull-high choice is passed straight through; interrupt use never overrides it.
	assign pin_pull_en = pin_pull_sel;

	assign events = {reload_done, buf_void, tick_ovf, timer_ovf, pin_event};

	// Only flag and enable together qualify; software-set flags count as well.
	assign pending = s.flag & s.en;

	irq_pick u_pick (
		.pending(pending),
		.found(found),
		.index(pick)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	// Zero wait states: every access completes in its first access cycle.
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign mapped = (paddr == irq_pkg::addr_edge_sel) || (paddr == irq_pkg::addr_ctrl0) ||
		(paddr == irq_pkg::addr_ctrl1) || (paddr == irq_pkg::addr_status);
	assign pslverr = psel & penable & ~mapped;
	assign prdata = s.rdata;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.pin_prev = irq_pin;
		next_s.wake = 1'b0;

		if (rd) begin
			next_s.rdata = 32'h0;
			unique case (paddr)
				irq_pkg::addr_edge_sel: next_s.rdata[1:0] = s.pin_edge_sel;
				irq_pkg::addr_ctrl0: next_s.rdata[7:0] = ctrl0_of(s);
				irq_pkg::addr_ctrl1: next_s.rdata[7:0] = ctrl1_of(s);
				irq_pkg::addr_status: next_s.rdata[3:0] = {s.phase == st_take, s.sel};
				default: next_s.rdata = 32'h0;
			endcase
		end

		if (wr) begin
			unique case (paddr)
				irq_pkg::addr_edge_sel: next_s.pin_edge_sel = pwdata[1:0];
				irq_pkg::addr_ctrl0: begin
					next_s.flag[irq_pkg::src_timer] = pwdata[irq_pkg::pos_timer_flag];
					next_s.flag[irq_pkg::src_pin] = pwdata[irq_pkg::pos_pin_flag];
					next_s.en[irq_pkg::src_timer] = pwdata[irq_pkg::pos_timer_en];
					next_s.en[irq_pkg::src_pin] = pwdata[irq_pkg::pos_pin_en];
					next_s.global_irq_en = pwdata[irq_pkg::pos_global_en];
				end
				irq_pkg::addr_ctrl1: begin
					next_s.flag[irq_pkg::src_reload] = pwdata[irq_pkg::pos_reload_flag];
					next_s.flag[irq_pkg::src_void] = pwdata[irq_pkg::pos_void_flag];
					next_s.flag[irq_pkg::src_tick] = pwdata[irq_pkg::pos_tick_flag];
					next_s.en[irq_pkg::src_reload] = pwdata[irq_pkg::pos_reload_en];
					next_s.en[irq_pkg::src_void] = pwdata[irq_pkg::pos_void_en];
					next_s.en[irq_pkg::src_tick] = pwdata[irq_pkg::pos_tick_en];
				end
				default: next_s.rdata = s.rdata;
			endcase
		end

		// Return from interrupt re-arms the global enable; a plain return leaves it.
		if (core_in.ret_irq) begin
			next_s.global_irq_en = 1'b1;
		end

		unique case (s.phase)
			st_idle: begin
				if (found && s.global_irq_en && !core_in.stack_full) begin
					next_s.phase = st_take;
					next_s.sel = pick;
					next_s.saved_pc = core_in.next_pc;
				end
			end
			st_take: begin
				if (core_in.take_ack) begin
					next_s.phase = st_idle;
					next_s.flag[s.sel] = 1'b0;
					next_s.global_irq_en = 1'b0;
				end
			end
			default: next_s.phase = st_idle;
		endcase

		// Events are applied last so a set beats any clear in the same cycle.
		for (int i = 0; i < irq_pkg::num_src; i++) begin
			if (events[i]) begin
				next_s.flag[i] = 1'b1;
			end
		end
		next_s.wake = |(next_s.flag & ~s.flag);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
			s.phase <= st_idle;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Core side
	// ----------------------------------------------------------------
	always_comb begin
		core_out.take_req = (s.phase == st_take);
		core_out.vector = vector_of(s.sel);
		core_out.push = (s.phase == st_take) & core_in.take_ack;
		core_out.push_pc = s.saved_pc;
		core_out.wake = s.wake;
	end
	// The core pops the stack itself on return; this block only re-arms the enable.

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_no_take_global_off;
		@(posedge clk) disable iff (!reset_n)
		(s.phase == st_idle && !s.global_irq_en) |=> s.phase == st_idle;
	endproperty
	a_no_take_global_off: assert property (p_no_take_global_off) else $error("take with global off");

	property p_no_take_stack_full;
		@(posedge clk) disable iff (!reset_n)
		(s.phase == st_idle && core_in.stack_full) |=> s.phase == st_idle;
	endproperty
	a_no_take_stack_full: assert property (p_no_take_stack_full) else $error("take on full stack");

	property p_take_when_ready;
		@(posedge clk) disable iff (!reset_n)
		(s.phase == st_idle && found && s.global_irq_en && !core_in.stack_full)
			|=> (s.phase == st_take && s.sel == $past(pick));
	endproperty
	a_take_when_ready: assert property (p_take_when_ready) else $error("ready request not taken");

	property p_ack_clears_global;
		@(posedge clk) disable iff (!reset_n)
		(core_out.push && !core_in.ret_irq && !wr) |=> !s.global_irq_en;
	endproperty
	a_ack_clears_global: assert property (p_ack_clears_global) else $error("global enable kept");

	property p_ack_clears_flag;
		@(posedge clk) disable iff (!reset_n)
		(core_out.push && !events[s.sel] && !wr) |=> !s.flag[$past(s.sel)];
	endproperty
	a_ack_clears_flag: assert property (p_ack_clears_flag) else $error("flag not cleared");

	property p_event_sets;
		@(posedge clk) disable iff (!reset_n)
		timer_ovf |=> s.flag[irq_pkg::src_timer];
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("timer flag not set");

	property p_irq_return_op_sets_global;
		@(posedge clk) disable iff (!reset_n)
		(core_in.ret_irq && !wr && !core_out.push) |=> s.global_irq_en;
	endproperty
	a_irq_return_op_sets_global: assert property (p_irq_return_op_sets_global) else $error("return left enable off");

	property p_wake_on_rise;
		@(posedge clk) disable iff (!reset_n)
		(!s.flag[irq_pkg::src_tick] && tick_ovf) |=> core_out.wake;
	endproperty
	a_wake_on_rise: assert property (p_wake_on_rise) else $error("no wake on flag rise");

	property p_vector_matches;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && s.sel == 3'h0) |-> core_out.vector == irq_pkg::vec_pin;
	endproperty
	a_vector_matches: assert property (p_vector_matches) else $error("wrong pin vector");

	property p_edge_off_quiet;
		@(posedge clk) disable iff (!reset_n)
		(s.pin_edge_sel == irq_pkg::edge_off && !s.flag[irq_pkg::src_pin] && !wr)
			|=> !s.flag[irq_pkg::src_pin];
	endproperty
	a_edge_off_quiet: assert property (p_edge_off_quiet) else $error("pin flag set while off");

	property p_rise_sets_pin;
		@(posedge clk) disable iff (!reset_n)
		(s.pin_edge_sel == irq_pkg::edge_rise && irq_pin && !s.pin_prev)
			|=> s.flag[irq_pkg::src_pin];
	endproperty
	a_rise_sets_pin: assert property (p_rise_sets_pin) else $error("rising edge missed");

	property p_fall_sets_pin;
		@(posedge clk) disable iff (!reset_n)
		(s.pin_edge_sel == irq_pkg::edge_fall && !irq_pin && s.pin_prev)
			|=> s.flag[irq_pkg::src_pin];
	endproperty
	a_fall_sets_pin: assert property (p_fall_sets_pin) else $error("falling edge missed");

	property p_void_sets;
		@(posedge clk) disable iff (!reset_n)
		buf_void |=> s.flag[irq_pkg::src_void];
	endproperty
	a_void_sets: assert property (p_void_sets) else $error("empty flag not set");

	property p_reload_sets;
		@(posedge clk) disable iff (!reset_n)
		reload_done |=> s.flag[irq_pkg::src_reload];
	endproperty
	a_reload_sets: assert property (p_reload_sets) else $error("reload flag not set");

	property p_tick_sets;
		@(posedge clk) disable iff (!reset_n)
		tick_ovf |=> s.flag[irq_pkg::src_tick];
	endproperty
	a_tick_sets: assert property (p_tick_sets) else $error("tick flag not set");

	property p_vector_timer;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && s.sel == 3'h1) |-> core_out.vector == irq_pkg::vec_timer;
	endproperty
	a_vector_timer: assert property (p_vector_timer) else $error("wrong timer vector");

	property p_vector_tick;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && s.sel == 3'h2) |-> core_out.vector == irq_pkg::vec_tick;
	endproperty
	a_vector_tick: assert property (p_vector_tick) else $error("wrong tick vector");

	property p_vector_void;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && s.sel == 3'h3) |-> core_out.vector == irq_pkg::vec_void;
	endproperty
	a_vector_void: assert property (p_vector_void) else $error("wrong empty vector");

	property p_vector_reload;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && s.sel == 3'h4) |-> core_out.vector == irq_pkg::vec_reload;
	endproperty
	a_vector_reload: assert property (p_vector_reload) else $error("wrong reload vector");

	property p_push_pc;
		@(posedge clk) disable iff (!reset_n)
		$rose(core_out.take_req) |-> core_out.push_pc == $past(core_in.next_pc);
	endproperty
	a_push_pc: assert property (p_push_pc) else $error("saved address wrong");

	property p_take_holds;
		@(posedge clk) disable iff (!reset_n)
		(core_out.take_req && !core_in.take_ack) |=> (core_out.take_req && $stable(s.sel));
	endproperty
	a_take_holds: assert property (p_take_holds) else $error("request dropped early");

	property p_no_wake_quiet;
		@(posedge clk) disable iff (!reset_n)
		(events == '0 && !wr) |=> !core_out.wake;
	endproperty
	a_no_wake_quiet: assert property (p_no_wake_quiet) else $error("wake without flag rise");

	property p_pin_first;
		@(posedge clk) disable iff (!reset_n)
		(s.phase == st_idle && found && s.global_irq_en && !core_in.stack_full &&
			pending[irq_pkg::src_pin]) |=> s.sel == 3'h0;
	endproperty
	a_pin_first: assert property (p_pin_first) else $error("pin not served first");

endmodule // irq_controller

/* File: test/core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Core and hardware stack of depth entries, two by default
// ----------------------------------------
module core_model #(parameter int depth = 2) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] ack_wait,
	input wire logic do_ret,
	input wire irq_pkg::core_out_t core_out,
	output irq_pkg::core_in_t core_in,
	output logic [11:0] resume_pc
);
	logic [11:0] stack [depth];
	int sp;
	int cnt;
	logic ack;
	logic ret;
	// The saved address is fixed so that a resume can be judged exactly.
	assign core_in = {12'h2a4, sp == depth, ret, 1'b0, ack};
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sp <= 0;
			cnt <= 0;
			ack <= 1'b0;
			ret <= 1'b0;
			resume_pc <= 12'h000;
		end else begin
			ack <= core_out.take_req && !ack && cnt >= int'(ack_wait);
			cnt <= (core_out.take_req && !ack) ? cnt + 1 : 0;
			ret <= do_ret && sp > 0;
			if (core_out.push) begin
				stack[sp] <= core_out.push_pc;
				sp <= sp + 1;
			end
			if (ret) begin
				resume_pc <= stack[sp - 1];
				sp <= sp - 1;
			end
		end
	end
endmodule // core_model

/* File: test/irq_controller_tb.sv */
`timescale 1ns/1ps
module irq_controller_tb;
	localparam logic [11:0] c0 = irq_pkg::addr_ctrl0;
	localparam logic [11:0] c1 = irq_pkg::addr_ctrl1;
	localparam logic [11:0] ce = irq_pkg::addr_edge_sel;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, do_ret = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, pin_pull_en, last_err, irq_pin = 0, timer_ovf = 0;
	logic tick_ovf = 0, buf_void = 0, reload_done = 0, pin_pull_sel = 0;
	logic [3:0] ack_wait = 4'h0;
	logic [11:0] last_vec, last_pc, resume_pc;
	irq_pkg::core_in_t core_in;
	irq_pkg::core_out_t core_out;
	int err_count = 0, checked = 0, push_cnt = 0, wake_cnt = 0;
	always #12.5 clk = ~clk;
	irq_controller u_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_pin(irq_pin), .timer_ovf(timer_ovf), .tick_ovf(tick_ovf),
		.buf_void(buf_void), .reload_done(reload_done), .pin_pull_sel(pin_pull_sel),
		.pin_pull_en(pin_pull_en), .core_in(core_in), .core_out(core_out));
	core_model #(.depth(1)) u_core (.clk(clk), .reset_n(reset_n), .ack_wait(ack_wait),
		.do_ret(do_ret), .core_out(core_out), .core_in(core_in), .resume_pc(resume_pc));
	always @(posedge clk) begin
		if (core_out.push === 1'b1) begin
			push_cnt++;
			last_vec = core_out.vector;
			last_pc = core_out.push_pc;
		end
		if (core_out.wake === 1'b1) wake_cnt++;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic wait_push(input int n);
		int k;
		k = 0;
		while (push_cnt == n && k < 40) begin
			@(posedge clk);
			k++;
		end
		check(32'(push_cnt), 32'(n + 1));
	endtask
	task automatic ret_pulse();
		do_ret <= 1'b1;
		@(posedge clk);
		do_ret <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(c0, 32'h0);
		rd(c1, 32'h0);
		rd(ce, 32'h0);
		wr(c0, 32'hfe);
		rd(c0, 32'h5a);
		wr(c1, 32'hff);
		rd(c1, 32'h77);
		wr(ce, 32'hff);
		rd(ce, 32'h03);
		rd(12'h010, 32'h0);
		check(32'(last_err), 32'h1);
		pin_pull_sel <= 1'b1;
		@(posedge clk);
		check(32'(pin_pull_en), 32'h1);
		pin_pull_sel <= 1'b0;
		@(posedge clk);
		check(32'(pin_pull_en), 32'h0);
		wr(c0, 32'h0);
		wr(c1, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_edge();
		for (int m = 0; m < 4; m++) begin
			wr(ce, 32'(m));
			irq_pin <= 1'b1;
			@(posedge clk);
			rd(c0, 32'(m % 2) << 4);
			wr(c0, 32'h0);
			irq_pin <= 1'b0;
			@(posedge clk);
			rd(c0, 32'(m / 2) << 4);
			wr(c0, 32'h0);
		end
		wr(ce, 32'h0);
		$display("test edge done");
	endtask
	task automatic t_gate();
		int n;
		int w;
		n = push_cnt;
		w = wake_cnt;
		timer_ovf <= 1'b1;
		@(posedge clk);
		timer_ovf <= 1'b0;
		rd(c0, 32'h40);
		check(32'(wake_cnt), 32'(w + 1));
		wr(c0, 32'h41);
		wr(c0, 32'h48);
		repeat (5) @(posedge clk);
		check(32'(push_cnt), 32'(n));
		wr(c0, 32'h49);
		wait_push(n);
		check(32'(last_vec), 32'(irq_pkg::vec_timer));
		check(32'(last_pc), 32'h2a4);
		rd(c0, 32'h08);
		tick_ovf <= 1'b1;
		buf_void <= 1'b1;
		reload_done <= 1'b1;
		@(posedge clk);
		tick_ovf <= 1'b0;
		buf_void <= 1'b0;
		reload_done <= 1'b0;
		rd(c1, 32'h70);
		check(32'(wake_cnt), 32'(w + 2));
		wr(c1, 32'h0);
		ret_pulse();
		wr(c0, 32'h0);
		$display("test gate done");
	endtask
	task automatic t_prio();
		logic [11:0] v [5];
		int n;
		v = '{irq_pkg::vec_pin, irq_pkg::vec_timer, irq_pkg::vec_tick, irq_pkg::vec_void,
			irq_pkg::vec_reload};
		wr(c1, 32'h77);
		n = push_cnt;
		wr(c0, 32'h5b);
		for (int i = 0; i < 5; i++) begin
			wait_push(n);
			check(32'(last_vec), 32'(v[i]));
			n = push_cnt;
			ret_pulse();
			check(32'(resume_pc), 32'h2a4);
		end
		rd(c0, 32'h0b);
		rd(c1, 32'h07);
		wr(c0, 32'h0);
		wr(c1, 32'h0);
		$display("test prio done");
	endtask
	task automatic t_full();
		int n;
		ack_wait <= 4'h3;
		n = push_cnt;
		wr(c0, 32'h49);
		wait_push(n);
		n = push_cnt;
		wr(c0, 32'h1b);
		repeat (10) @(posedge clk);
		check(32'(push_cnt), 32'(n));
		ret_pulse();
		wait_push(n);
		check(32'(last_vec), 32'(irq_pkg::vec_pin));
		rd(c0, 32'h0a);
		ret_pulse();
		wr(c0, 32'h0);
		$display("test full done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// A hang anywhere ends the run as a failure.
	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_edge();
		t_gate();
		t_prio();
		t_full();
		report_and_stop();
	end
endmodule // irq_controller_tb
